/* File: rtl/tss_top.sv */
// Top of the touch-sense spread-spectrum and decimation logic.
// Assumes trigger and start pulses come from same-clock front-end logic;
// the electrode pulse input is a pin and is synchronised here.
module tss_top
  import tss_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                            ref_clk_i,
  input  wire logic                            arst_n_i,
  input  wire logic                            clk_en_i,
  // Configuration
  input  wire tss_spread_control_register_type spread_control_register_i,
  input  wire logic [5:0]                      decim_i,
  input  wire logic                            gie_i,
  input  wire logic                            eos_ie_i,
  input  wire logic                            oor_ie_i,
  input  wire logic [CNT_W-1:0]                thr_lo_i,
  input  wire logic [CNT_W-1:0]                thr_hi_i,
  // Front end
  input  wire logic                            scan_start_i,
  input  wire logic                            trig_i,
  input  wire logic                            sense_pulse_i,
  input  wire logic                            flag_clr_eos_i,
  input  wire logic                            flag_clr_oor_i,
  // Outputs
  output logic                                 excite_o,
  output logic [ACC_W-1:0]                     accumulated_count_o,
  output tss_flags_type                        flags_o,
  output logic                                 scan_busy_o,
  output logic                                 irq_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01
  } tss_fsm_type;

  typedef struct packed {
    tss_fsm_type       fsm;
    logic [1:0]        sync;
    logic              sync_d;
    logic [LFSR_W-1:0] lfsr;
    logic [3:0]        updn;
    logic              updn_dir;
    logic [4:0]        hold;
    logic              bit_val;
    logic [5:0]        periods;
    logic [ACC_W-1:0]  acc;
    logic [ACC_W-1:0]  result;
    tss_flags_type     flags;
  } tss_state_type;

  tss_state_type state;
  tss_state_type next_state;
  logic          pre_tick;

  // Legal decimation count, clamped into 1..32
  function automatic logic [5:0] clamp_dec(input logic [5:0] d);
    if (d == 6'h00)
      return 6'h01;
    else if (d > DEC_MAX)
      return DEC_MAX;
    else
      return d;
  endfunction : clamp_dec

  // Legal sequence length, clamped into 2..15
  function automatic logic [3:0] clamp_len(input logic [3:0] l);
    return (l < LEN_MIN) ? LEN_MIN : l;
  endfunction : clamp_len

  // Mask of the sequence bits that feed back for the given length
  function automatic logic [LFSR_W-1:0] len_mask(input logic [3:0] l);
    logic [LFSR_W-1:0] m;
    m = '0;
    for (int i = 0; i < LFSR_W; i++)
    begin
      if (i < int'(l))
        m[i] = 1'b1;
    end
    return m;
  endfunction : len_mask

  // RULE_07: bit clock prescaler
  tss_prescaler u_pre (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .en_i      (clk_en_i),
    .therm_i   (spread_control_register_i.prescale),
    .tick_o    (pre_tick)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [3:0] len;
    logic       new_bit;
    logic       sense_rise;
    logic [5:0] dec;
    logic       oor_set;
    len        = clamp_len(spread_control_register_i.sequence_length_select);
    dec        = clamp_dec(decim_i);
    new_bit    = 1'b0;
    oor_set    = 1'b0;
    next_state = state;
    // Two-stage pin synchroniser; only the second stage is examined
    next_state.sync   = {state.sync[0], sense_pulse_i};
    next_state.sync_d = state.sync[1];
    sense_rise        = state.sync[1] && !state.sync_d;

    // RULE_09: bit held for its programmed length
    // Hold counts prescaled ticks so the duration scales with the divider
    if (pre_tick)
    begin
      if (state.hold != 5'h00)
      begin
        next_state.hold = 5'(state.hold - 5'h01);
      end
      else
      begin
        case (spread_control_register_i.mode)
          // RULE_05: pseudo-random output
          TSS_MODE_PRBS:
          begin
            next_state.lfsr = {state.lfsr[LFSR_W-2:0],
                               state.lfsr[len-4'h1] ^ state.lfsr[0]};
            // A shorter length can leave the active bits all zero; reseed then
            if ((next_state.lfsr & len_mask(len)) == '0)
            begin
              next_state.lfsr = LFSR_SEED;
            end
            new_bit = state.lfsr[len-4'h1];
          end
          // RULE_06: up-down counter output
          TSS_MODE_UPDN:
          begin
            if (state.updn_dir)
            begin
              next_state.updn = 4'(state.updn + 4'h1);
              if (state.updn == LEN_MAX - 4'h1)
                next_state.updn_dir = 1'b0;
            end
            else
            begin
              next_state.updn = 4'(state.updn - 4'h1);
              if (state.updn == 4'h1)
                next_state.updn_dir = 1'b1;
            end
            new_bit = state.updn[0];
          end
          default:
          begin
            new_bit = 1'b0;
          end
        endcase
        next_state.bit_val = new_bit;
        // RULE_03: zero bit duration
        // RULE_04: one bit basic duration
        next_state.hold = new_bit ? {1'b0, spread_control_register_i.one_len_m1}
                                  : {1'b0, spread_control_register_i.zero_len_m1};
      end
    end

    // RULE_01: accumulate over decimation periods
    case (state.fsm)
      ST_IDLE:
      begin
        if (scan_start_i)
        begin
          next_state.fsm     = ST_SCAN;
          next_state.acc     = '0;
          next_state.periods = '0;
        end
      end
      ST_SCAN:
      begin
        if (sense_rise)
        begin
          next_state.acc = ACC_W'(state.acc + 1'b1);
        end
        // RULE_02: any count 1..32 ends the scan
        if (trig_i)
        begin
          next_state.periods = 6'(state.periods + 6'h01);
          if (6'(state.periods + 6'h01) >= dec)
          begin
            next_state.fsm    = ST_IDLE;
            next_state.result = next_state.acc;
            next_state.flags.eos = 1'b1;
            if (next_state.acc[CNT_W-1:0] < thr_lo_i ||
                next_state.acc[CNT_W-1:0] > thr_hi_i)
            begin
              next_state.flags.oor = 1'b1;
              oor_set              = 1'b1;
            end
          end
        end
      end
      default:
      begin
        next_state.fsm = ST_IDLE;
      end
    endcase

    // RULE_08: flags clear, set wins
    if (flag_clr_eos_i && !(state.fsm == ST_SCAN && next_state.fsm == ST_IDLE))
      next_state.flags.eos = 1'b0;
    if (flag_clr_oor_i && !oor_set)
      next_state.flags.oor = 1'b0;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state          <= '0;
      state.lfsr     <= LFSR_SEED;
      state.updn_dir <= 1'b1;
    end
    else if (clk_en_i)
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // RULE_06: off mode forces the line low
  assign excite_o            = (spread_control_register_i.mode == TSS_MODE_OFF) ? 1'b0
                               : state.bit_val;
  assign accumulated_count_o = state.result;
  assign flags_o             = state.flags;
  assign scan_busy_o         = (state.fsm == ST_SCAN);
  // RULE_09: interrupt gated by both enables
  assign irq_o = gie_i && ((eos_ie_i && state.flags.eos) || (oor_ie_i && state.flags.oor));

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_irq_gating: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_08
    irq_o |-> gie_i && (state.flags.eos || state.flags.oor))
    else $error("interrupt without enabled flag");
  a_irq_global: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_09
    (gie_i && eos_ie_i && state.flags.eos) |-> irq_o)
    else $error("enabled end-of-scan did not interrupt");
  a_off_low: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_06
    (spread_control_register_i.mode == TSS_MODE_OFF) |-> !excite_o)
    else $error("excitation active while off");
  a_hold_max: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_03
    state.hold <= 5'h0F)
    else $error("hold count beyond sixteen");
  a_eos_set: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_01
    (clk_en_i && state.fsm == ST_SCAN && trig_i &&
     6'(state.periods + 6'h01) >= clamp_dec(decim_i)) |=> state.flags.eos)
    else $error("end of scan flag missed");
  a_dec_bound: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_02
    state.periods <= DEC_MAX)
    else $error("period count over limit");
  a_lfsr_live: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_05
    state.lfsr != '0)
    else $error("sequence register stuck at zero");
  a_result_load: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_01
    $fell(scan_busy_o) |-> accumulated_count_o == state.acc)
    else $error("result not loaded at scan end");
  a_bit_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_04
    (clk_en_i && state.hold != 5'h00) |=> $stable(state.bit_val))
    else $error("bit changed during hold");
endmodule : tss_top

/* File: rtl/tss_pkg.sv */
// Constants and carrier types of the touch-sense spread and decimation block.
// Assumes one system clock; configuration ports are static while a scan runs.
// Summary of operation
// RULE_01: Result accumulates counts over up to 32 periods
// RULE_02: Decimation selectable from 1 to 32
// RULE_03: Zero bit lasts 1 to 16 clocks
// RULE_04: One bit basic length 1 to 16 clocks
// RULE_05: Pseudo-random sequence length programmable 2 to 15
// RULE_06: Modes: pseudo-random, up-down counter, or off
// RULE_07: Thermometer-coded power-of-two prescaler, 1 to 256
// RULE_08: End-of-scan, out-of-range flags with enables
// RULE_09: Hold each bit; interrupt needs both enables
package tss_pkg;
  // ---------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------
  localparam int          CNT_W      = 16;
  localparam int          ACC_W      = 24;
  localparam int          LFSR_W     = 15;
  localparam logic [5:0]  DEC_MAX    = 6'h20;
  localparam logic [3:0]  LEN_MIN    = 4'h2;
  localparam logic [3:0]  LEN_MAX    = 4'hF;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h0001;
  localparam logic [7:0]  PRE_DIV1   = 8'h00;

  // Excitation modes
  typedef enum logic [1:0] {
    TSS_MODE_PRBS = 2'b00,
    TSS_MODE_UPDN = 2'b01,
    TSS_MODE_OFF  = 2'b10
  } tss_mode_type;

  // Spread control settings
  typedef struct packed {
    tss_mode_type mode;
    logic [3:0]   zero_len_m1;   // Zero bit length minus one
    logic [3:0]   one_len_m1;    // One bit basic length minus one
    logic [3:0]   sequence_length_select;
    logic [7:0]   prescale;      // Thermometer code
  } tss_spread_control_register_type;

  // Status flags
  typedef struct packed {
    logic eos;
    logic oor;
  } tss_flags_type;
endpackage : tss_pkg

/* File: rtl/tss_prescaler.sv */
// Power-of-two prescaler with thermometer-coded ratio.
// Assumes the code is one of the nine legal thermometer values.
module tss_prescaler
  import tss_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       en_i,
  // Ratio
  input  wire logic [7:0] therm_i,
  // Tick out
  output logic            tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
  } tss_pre_state_type;

  tss_pre_state_type state;
  tss_pre_state_type next_state;

  // RULE_07: thermometer terminal count
  // Each set code bit doubles the ratio, so the terminal count is the code itself
  always_comb
  begin
    next_state = state;
    if ((state.cnt & therm_i) == therm_i)
    begin
      next_state.cnt = PRE_DIV1;
    end
    else
    begin
      next_state.cnt = 8'((state.cnt + 8'h01) & therm_i);
    end
  end

  assign tick_o = en_i && ((state.cnt & therm_i) == therm_i);

  // State register
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= '0;
    end
    else if (en_i)
    begin
      state <= next_state;
    end
  end
endmodule : tss_prescaler

/* File: dv/tss_front_end_model.sv */
// Behavioural electrode front end: sense pulses and trigger period ends.
// Assumes period() is called from a process aligned to the falling edge.
module tss_front_end_model
(
  // Clock
  input  wire logic ref_clk_i,
  // Toward the block
  output logic      trig_o,
  output logic      sense_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    trig_o = 1'b0;
    sense_o = 1'b0;
  end

  // Pulses are two cycles wide so the two-stage sync cannot miss one;
  // the idle gap covers the sync latency before the period closes
  task automatic period(input int n);
    repeat (n)
    begin
      @(negedge ref_clk_i) sense_o = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      sense_o = 1'b0;
      @(negedge ref_clk_i);
    end
    repeat (4) @(negedge ref_clk_i);
    trig_o = 1'b1;
    @(negedge ref_clk_i) trig_o = 1'b0;
  endtask : period
endmodule : tss_front_end_model

/* File: dv/test_touch_sense_ssc_decimation.sv */
// Self-checking bench for the spread-spectrum and decimation block.
// Assumes inputs change on the falling edge only; random seed is fixed.
module test_touch_sense_ssc_decimation import tss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                            ref_clk_i;
  logic                            arst_n_i;
  logic                            clk_en_i;
  tss_spread_control_register_type cfg;
  logic [5:0]                      decim_i;
  logic                            gie_i;
  logic                            eos_ie_i;
  logic                            oor_ie_i;
  logic [CNT_W-1:0]                thr_lo_i;
  logic [CNT_W-1:0]                thr_hi_i;
  logic                            scan_start_i;
  logic                            flag_clr_eos_i;
  logic                            flag_clr_oor_i;
  logic                            trig;
  logic                            sense;
  logic                            excite;
  logic [ACC_W-1:0]                acc;
  tss_flags_type                   flags;
  logic                            busy;
  logic                            irq;
  int                              errors;
  int                              n_checks;
  int                              seed;
  int                              run;
  logic                            last_x;
  logic                            seen_edge;
  logic [5:0]                      dtab [8] = '{6'h00, 6'h01, 6'h0B, 6'h0C, 6'h1F, 6'h20, 6'h21, 6'h3F};

  tss_top tss_top_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .spread_control_register_i(cfg), .decim_i(decim_i), .gie_i(gie_i), .eos_ie_i(eos_ie_i),
    .oor_ie_i(oor_ie_i), .thr_lo_i(thr_lo_i), .thr_hi_i(thr_hi_i),
    .scan_start_i(scan_start_i), .trig_i(trig), .sense_pulse_i(sense),
    .flag_clr_eos_i(flag_clr_eos_i), .flag_clr_oor_i(flag_clr_oor_i), .excite_o(excite),
    .accumulated_count_o(acc), .flags_o(flags), .scan_busy_o(busy), .irq_o(irq));
  tss_front_end_model tss_front_end_model_i (.ref_clk_i(ref_clk_i), .trig_o(trig),
    .sense_o(sense));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [ACC_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Out-of-range codes clamp to the nearest legal count
  function automatic int eff_dec(input logic [5:0] d);
    return (d == 6'h00) ? 1 : (d > DEC_MAX) ? int'(DEC_MAX) : int'(d);
  endfunction : eff_dec

  function automatic int bitlen(input logic x);
    return ((x ? cfg.one_len_m1 : cfg.zero_len_m1) + 1) << $countones(cfg.prescale);
  endfunction : bitlen

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Runs of equal bits must be whole bit lengths; the first run after
  // scan start may be partial, so it is skipped
  // Sampled on the falling edge, where the registered outputs have settled
  always @(negedge ref_clk_i)
  begin
    if (!busy || cfg.mode == TSS_MODE_OFF)
    begin
      if (busy)
        check("excite_off", excite, 0);
      seen_edge = 1'b0;
      run = 0;
    end
    else if (excite !== last_x)
    begin
      if (seen_edge)
        check("excite_run", run % bitlen(last_x), 0);
      seen_edge = 1'b1;
      run = 1;
    end
    else
      run++;
    last_x = excite;
  end

  // One scan with random settings; a second start mid-scan must be ignored
  task automatic scan(input logic [5:0] d);
    int n;
    int e;
    logic oor;
    n = 1 + ($unsigned($random(seed)) % 4);
    e = eff_dec(d);
    @(negedge ref_clk_i);
    cfg = $bits(cfg)'($random(seed));
    cfg.mode = tss_mode_type'($unsigned($random(seed)) % 3);
    cfg.prescale = 8'hFF >> ($unsigned($random(seed)) % 9);
    decim_i = d;
    {gie_i, eos_ie_i, oor_ie_i} = 3'($random(seed));
    thr_lo_i = 16'($unsigned($random(seed)) % 64);
    thr_hi_i = thr_lo_i + 16'($unsigned($random(seed)) % 64);
    flag_clr_eos_i = 1'b1;
    flag_clr_oor_i = 1'b1;
    @(negedge ref_clk_i);
    check("flags_clr", flags, 0);
    flag_clr_eos_i = 1'b0;
    flag_clr_oor_i = 1'b0;
    scan_start_i = 1'b1;
    @(negedge ref_clk_i) scan_start_i = 1'b0;
    for (int p = 0; p < e; p++)
    begin
      // Clears held across the closing trigger: the set must win
      if (p == e - 1)
        {flag_clr_eos_i, flag_clr_oor_i} = 2'($random(seed));
      tss_front_end_model_i.period(n);
      if (p < e - 1)
      begin
        scan_start_i = 1'b1;
        @(negedge ref_clk_i) scan_start_i = 1'b0;
      end
    end
    {flag_clr_eos_i, flag_clr_oor_i} = 2'b00;
    for (int w = 0; w < 10 && busy !== 1'b0; w++)
      @(negedge ref_clk_i);
    oor = ((e * n) < int'(thr_lo_i)) || ((e * n) > int'(thr_hi_i));
    check("busy", busy, 0);
    check("count", acc, e * n);
    check("eos", flags.eos, 1);
    check("oor", flags.oor, oor);
    check("irq", irq, gie_i & (eos_ie_i | (oor & oor_ie_i)));
  endtask : scan

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    // Worst case is about 20k cycles of scans; allow 50k before giving up
    #400000;
    errors++;
    finish_test();
  end

  initial
  begin
    seed = 32'hB1010D24;
    {arst_n_i, clk_en_i, gie_i, eos_ie_i, oor_ie_i} = '0;
    {scan_start_i, flag_clr_eos_i, flag_clr_oor_i} = '0;
    cfg = '0;
    decim_i = 6'h01;
    thr_lo_i = '0;
    thr_hi_i = '0;
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i) arst_n_i = 1'b1;
    // A start while frozen is not taken
    scan_start_i = 1'b1;
    @(negedge ref_clk_i) scan_start_i = 1'b0;
    @(negedge ref_clk_i);
    check("busy_frozen", busy, 0);
    clk_en_i = 1'b1;
    foreach (dtab[i])
      scan(dtab[i]);
    repeat (24)
      scan(6'($unsigned($random(seed)) % 34));
    finish_test();
  end
endmodule : test_touch_sense_ssc_decimation
